//--- cfg_port_pkg.sv
`default_nettype none
package cfg_port_pkg;

    localparam int unsigned ADDR_W   = 10;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned BE_W     = 4;
    localparam int unsigned OFS_W    = 12;
    localparam int unsigned NUM_CAPS = 5;
    localparam int unsigned DEPTH    = 1024;

    // capability order inside the extended space
    localparam int unsigned CAP_DSN  = 0;
    localparam int unsigned CAP_VC   = 1;
    localparam int unsigned CAP_VSEC = 2;
    localparam int unsigned CAP_AER  = 3;
    localparam int unsigned CAP_RBAR = 4;

    localparam logic [OFS_W-1:0] EXT_BASE   = 12'h100;
    localparam logic [OFS_W-1:0] LEGACY_END = 12'h100;

    // structure lengths in bytes, in chain order
    localparam logic [OFS_W-1:0] CAP_SIZE [NUM_CAPS] = '{
        12'h00c, 12'h01c, 12'h018, 12'h038, 12'h00c};
    localparam logic [15:0] CAP_ID [NUM_CAPS] = '{
        16'h0003, 16'h0002, 16'h000b, 16'h0001, 16'h0015};
    localparam logic [3:0] CAP_VER = 4'h1;

    // writable fields of the legacy header
    localparam logic [ADDR_W-1:0] CMD_DW       = 10'h001;
    localparam logic [DATA_W-1:0] CMD_MASK     = 32'h0000_0545;
    localparam logic [ADDR_W-1:0] CACHE_DW     = 10'h003;
    localparam logic [DATA_W-1:0] CACHE_MASK   = 32'h0000_00ff;
    localparam logic [ADDR_W-1:0] BAR_FIRST_DW = 10'h004;
    localparam logic [ADDR_W-1:0] BAR_LAST_DW  = 10'h009;
    localparam logic [ADDR_W-1:0] INTLINE_DW   = 10'h00f;
    localparam logic [DATA_W-1:0] INTLINE_MASK = 32'h0000_00ff;

    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [4:0]        RESET_CAPS = 5'h00;

    typedef enum logic [0:0] {
        DEV_IDLE = 1'b0,
        DEV_DONE = 1'b1
    } dev_state_e;

    typedef enum logic [0:0] {
        REQ_IDLE = 1'b0,
        REQ_WAIT = 1'b1
    } req_state_e;

    // base of structure idx: extended base plus lengths of enabled predecessors
    function automatic logic [OFS_W-1:0] cap_base(input int unsigned idx,
                                                  input logic [4:0] en);
        logic [OFS_W-1:0] b;
        b = EXT_BASE;
        for (int unsigned i = 0; i < NUM_CAPS; i++) begin
            if (i < idx && en[i]) begin
                b = b + CAP_SIZE[i];
            end
        end
        return b;
    endfunction

    // base of the next enabled structure, zero closes the chain
    function automatic logic [OFS_W-1:0] cap_next(input int unsigned idx,
                                                  input logic [4:0] en);
        logic [OFS_W-1:0] n;
        logic             found;
        n = '0;
        found = 1'b0;
        for (int unsigned i = 0; i < NUM_CAPS; i++) begin
            if (i > idx && en[i] && !found) begin
                n = cap_base(i, en);
                found = 1'b1;
            end
        end
        return n;
    endfunction

endpackage
`default_nettype wire

//--- cfg_port_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cfg_port_if;
    import cfg_port_pkg::*;

    logic [ADDR_W-1:0] cfg_dwaddr;
    logic [DATA_W-1:0] cfg_write_data_in;
    logic [BE_W-1:0]   cfg_byte_en;
    logic              cfg_wr_en;
    logic              cfg_rd_en;
    logic [DATA_W-1:0] cfg_read_data;
    logic              cfg_rd_wr_done;

    modport device (
        input  cfg_dwaddr,
        input  cfg_write_data_in,
        input  cfg_byte_en,
        input  cfg_wr_en,
        input  cfg_rd_en,
        output cfg_read_data,
        output cfg_rd_wr_done
    );

    modport requester (
        output cfg_dwaddr,
        output cfg_write_data_in,
        output cfg_byte_en,
        output cfg_wr_en,
        output cfg_rd_en,
        input  cfg_read_data,
        input  cfg_rd_wr_done
    );
endinterface
`default_nettype wire

//--- cfg_space_device.sv
// Summary of operation
// - requester gives dword address, not byte address
// - read returns full 32-bit addressed register
// - read data valid only with done strobe
// - only read-write bits accept port writes
// - byte enables select updated lanes
// - requester holds request until done strobe
// - root port initialises space through this port
// - structures chained in order dsn vc vsec aer rbar
// - first at 100h, vc after dsn at 10ch
// - vsec at 100h, 10ch, 11ch or 128h
// - aer at 11ch after vc, 118h after vsec
// - aer two or three predecessor bases
// - rbar single predecessor bases
// - rbar bases after two or three early structures
// - rbar after aer plus one predecessor
// - rbar after aer plus two, 178h all five
// - unoccupied extended space left unimplemented
`timescale 1ns/100ps
`default_nettype none
module cfg_space_device
    import cfg_port_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   srst,
    cfg_port_if.device                  cfg,
    input  wire logic [4:0]             cap_enable,
    output logic [OFS_W-1:0]            cap_base_out [NUM_CAPS],
    output logic [OFS_W-1:0]            ext_free_base,
    output logic                        user_space_hit,
    output logic                        write_dropped
);
    import cfg_port_pkg::*;

    dev_state_e             state;
    logic [DATA_W-1:0]      space [DEPTH];
    logic [4:0]             caps;
    logic [OFS_W-1:0]       byte_addr;
    logic [OFS_W-1:0]       base [NUM_CAPS];
    logic [NUM_CAPS-1:0]    hit_hdr;
    logic [NUM_CAPS-1:0]    hit_body;
    logic [DATA_W-1:0]      hdr_word [NUM_CAPS];
    logic [DATA_W-1:0]      lane_mask;
    logic [DATA_W-1:0]      rw_mask;
    logic [DATA_W-1:0]      write_mask;
    logic [DATA_W-1:0]      rd_word;
    logic [DATA_W-1:0]      next_word;
    logic                   ext_claimed;
    logic                   take;

    // the address is a dword index; shift back to bytes only to compare bases
    assign byte_addr = {cfg.cfg_dwaddr, 2'b00};

    // a request already answered is still held; ignore it until idle again
    assign take = (state == DEV_IDLE) && (cfg.cfg_rd_en || cfg.cfg_wr_en);

    // enables are a build choice; caught while reset is applied, stable afterwards
    always_ff @(posedge clock) begin
        if (srst) begin
            caps <= cap_enable;
        end
    end

    generate
        for (genvar g = 0; g < NUM_CAPS; g++) begin : g_cap
            assign base[g] = cap_base(g, caps);
            assign hit_hdr[g] = caps[g] && (byte_addr == base[g]);
            assign hit_body[g] = caps[g] && (byte_addr > base[g])
                && (byte_addr < base[g] + CAP_SIZE[g]);
            // headers are read-only: id, version and link to the next one
            assign hdr_word[g] = {cap_next(g, caps), CAP_VER, CAP_ID[g]};
        end
    endgenerate

    generate
        for (genvar b = 0; b < BE_W; b++) begin : g_lane
            assign lane_mask[8*b +: 8] = {8{cfg.cfg_byte_en[b]}};
        end
    endgenerate

    // any enabled structure that owns this dword
    assign ext_claimed = |{hit_hdr, hit_body};

    // legacy header: only the few read-write fields keep storage
    always_comb begin
        rd_word = RESET_WORD;
        rw_mask = '0;
        if (byte_addr < LEGACY_END) begin
            rd_word = space[cfg.cfg_dwaddr];
            if (cfg.cfg_dwaddr == CMD_DW) begin
                rw_mask = CMD_MASK;
            end else if (cfg.cfg_dwaddr == CACHE_DW) begin
                rw_mask = CACHE_MASK;
            end else if (cfg.cfg_dwaddr >= BAR_FIRST_DW
                         && cfg.cfg_dwaddr <= BAR_LAST_DW) begin
                rw_mask = '1;
            end else if (cfg.cfg_dwaddr == INTLINE_DW) begin
                rw_mask = INTLINE_MASK;
            end else begin
                rw_mask = '0;
            end
        end else begin
            for (int unsigned i = 0; i < NUM_CAPS; i++) begin
                if (hit_hdr[i]) begin
                    rd_word = hdr_word[i];
                end else if (hit_body[i]) begin
                    rd_word = space[cfg.cfg_dwaddr];
                    rw_mask = '1;
                end
            end
        end
    end

    // unclaimed extended space stays zero and never stores: free for user logic
    assign write_mask = rw_mask & lane_mask;
    assign next_word = (space[cfg.cfg_dwaddr] & ~write_mask)
        | (cfg.cfg_write_data_in & write_mask);

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= DEV_IDLE;
        end else begin
            case (state)
                DEV_IDLE: begin
                    if (take) begin
                        state <= DEV_DONE;
                    end
                end
                DEV_DONE: begin
                    state <= DEV_IDLE;
                end
                default: begin
                    state <= DEV_IDLE;
                end
            endcase
        end
    end

    // exactly one strobe per taken request, one cycle after it is taken
    always_ff @(posedge clock) begin
        if (srst) begin
            cfg.cfg_rd_wr_done <= 1'b0;
        end else begin
            cfg.cfg_rd_wr_done <= take;
        end
    end

    // a write-and-read request returns the word as it was before the write
    always_ff @(posedge clock) begin
        if (srst) begin
            cfg.cfg_read_data <= RESET_WORD;
        end else if (take && cfg.cfg_rd_en) begin
            cfg.cfg_read_data <= rd_word;
        end
    end

    // full clear costs area but gives every register a known value after reset
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int unsigned i = 0; i < DEPTH; i++) begin
                space[i] <= RESET_WORD;
            end
        end else if (take && cfg.cfg_wr_en) begin
            space[cfg.cfg_dwaddr] <= next_word;
        end
    end

    // lets user logic serve its own structures in the free extended space
    always_ff @(posedge clock) begin
        if (srst) begin
            user_space_hit <= 1'b0;
        end else begin
            user_space_hit <= take && (byte_addr >= EXT_BASE) && !ext_claimed;
        end
    end

    // a dropped write still completes normally; this pulse is its only trace
    always_ff @(posedge clock) begin
        if (srst) begin
            write_dropped <= 1'b0;
        end else begin
            write_dropped <= take && cfg.cfg_wr_en && (write_mask == '0);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ext_free_base <= EXT_BASE;
        end else begin
            // first byte after the last enabled structure
            ext_free_base <= cap_base(NUM_CAPS, caps);
        end
    end

    // out of reset, disabled structures report zero so no base is mistaken for a live one; during reset every base reads 100h
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int unsigned i = 0; i < NUM_CAPS; i++) begin
                cap_base_out[i] <= EXT_BASE;
            end
        end else begin
            for (int unsigned i = 0; i < NUM_CAPS; i++) begin
                cap_base_out[i] <= caps[i] ? base[i] : '0;
            end
        end
    end

endmodule // cfg_space_device
`default_nettype wire

//--- cfg_space_requester.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_space_requester
    import cfg_port_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   srst,
    cfg_port_if.requester               cfg,
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire logic                   req_read,
    input  wire logic [OFS_W-1:0]       req_byte_addr,
    input  wire logic [DATA_W-1:0]      req_wdata,
    input  wire logic [BE_W-1:0]        req_byte_en,
    output logic                        req_ready,
    output logic                        resp_valid,
    output logic [DATA_W-1:0]           resp_rdata
);
    import cfg_port_pkg::*;

    req_state_e state;

    assign req_ready = (state == REQ_IDLE);

    // root port setup and endpoint accesses both pass through here
    always_ff @(posedge clock) begin
        if (srst) begin
            state                 <= REQ_IDLE;
            cfg.cfg_dwaddr        <= '0;
            cfg.cfg_write_data_in <= RESET_WORD;
            cfg.cfg_byte_en       <= '0;
            cfg.cfg_wr_en         <= 1'b0;
            cfg.cfg_rd_en         <= 1'b0;
        end else begin
            case (state)
                REQ_IDLE: begin
                    if (req_valid && (req_write || req_read)) begin
                        state                 <= REQ_WAIT;
                        cfg.cfg_dwaddr        <= req_byte_addr[OFS_W-1:2];
                        cfg.cfg_write_data_in <= req_wdata;
                        cfg.cfg_byte_en       <= req_byte_en;
                        cfg.cfg_wr_en         <= req_write;
                        cfg.cfg_rd_en         <= req_read && !req_write;
                    end
                end
                REQ_WAIT: begin
                    // everything held until the strobe, then the read and write enables dropped
                    if (cfg.cfg_rd_wr_done) begin
                        state         <= REQ_IDLE;
                        cfg.cfg_wr_en <= 1'b0;
                        cfg.cfg_rd_en <= 1'b0;
                    end
                end
                default: begin
                    state <= REQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            resp_valid <= 1'b0;
            resp_rdata <= RESET_WORD;
        end else begin
            resp_valid <= (state == REQ_WAIT) && cfg.cfg_rd_wr_done;
            if ((state == REQ_WAIT) && cfg.cfg_rd_wr_done && cfg.cfg_rd_en) begin
                resp_rdata <= cfg.cfg_read_data;
            end
        end
    end

endmodule // cfg_space_requester
`default_nettype wire

//--- config_port_ext_cap_map_props.sv
`timescale 1ns/100ps
`default_nettype none
module config_port_ext_cap_map_props
    import cfg_port_pkg::*;
(
    input wire logic              clock,
    input wire logic              srst,
    input wire logic [ADDR_W-1:0] cfg_dwaddr,
    input wire logic [DATA_W-1:0] cfg_write_data_in,
    input wire logic [BE_W-1:0]   cfg_byte_en,
    input wire logic              cfg_wr_en,
    input wire logic              cfg_rd_en,
    input wire logic [DATA_W-1:0] cfg_read_data,
    input wire logic              cfg_rd_wr_done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_done_one_cycle: assert property (cfg_rd_wr_done |=> !cfg_rd_wr_done)
        else $error("done strobe wider than one cycle");
    a_done_after_req: assert property ($rose(cfg_rd_en || cfg_wr_en) |=> cfg_rd_wr_done)
        else $error("done did not follow the request");
    a_done_needs_req: assert property (cfg_rd_wr_done |-> $past(cfg_rd_en || cfg_wr_en))
        else $error("done without a request");
    a_hold_fields: assert property ((cfg_wr_en && !cfg_rd_wr_done) |=>
        cfg_wr_en && $stable(cfg_dwaddr) && $stable(cfg_write_data_in) && $stable(cfg_byte_en))
        else $error("write request changed before done");
    a_req_drops: assert property (cfg_rd_wr_done |=> !(cfg_rd_en || cfg_wr_en))
        else $error("request still high after done");
    a_read_stable: assert property (!cfg_rd_en |=> $stable(cfg_read_data))
        else $error("read data moved without a read");
    a_done_bounded: assert property ((cfg_rd_en || cfg_wr_en) |-> ##[0:1] cfg_rd_wr_done)
        else $error("request not completed in time");
    a_release_after_done: assert property ($fell(cfg_rd_en || cfg_wr_en) |-> $past(cfg_rd_wr_done))
        else $error("request released before done");
endmodule // config_port_ext_cap_map_props
`default_nettype wire

//--- config_port_ext_cap_map_tb.sv
`timescale 1ns/100ps
`default_nettype none
module config_port_ext_cap_map_tb;
    import cfg_port_pkg::*;
    typedef struct packed {
        logic [4:0]       en;
        logic [2:0]       idx;
        logic [OFS_W-1:0] base;
    } row_s;
    logic              clock         = 1'b0;
    logic              srst          = 1'b1;
    logic [4:0]        cap_enable    = 5'h1f;
    logic              req_valid     = 1'b0;
    logic              req_write     = 1'b0;
    logic              req_read      = 1'b0;
    logic [OFS_W-1:0]  req_byte_addr = '0;
    logic [DATA_W-1:0] req_wdata     = '0;
    logic [BE_W-1:0]   req_byte_en   = '0;
    logic              req_ready;
    logic              resp_valid;
    logic [DATA_W-1:0] resp_rdata;
    logic [OFS_W-1:0]  cap_base_out [NUM_CAPS];
    logic [OFS_W-1:0]  ext_free_base;
    logic [DATA_W-1:0] rd;
    logic              user_space_hit;
    logic              write_dropped;
    logic              hit_seen      = 1'b0;
    logic              drop_seen     = 1'b0;
    int                failures      = 0;
    int                compares      = 0;
    // enable mask, structure index, expected base
    row_s rows [27] = '{
        '{5'h01, 3'h0, 12'h100}, '{5'h03, 3'h1, 12'h10c}, '{5'h02, 3'h1, 12'h100},
        '{5'h04, 3'h2, 12'h100}, '{5'h05, 3'h2, 12'h10c}, '{5'h07, 3'h2, 12'h128},
        '{5'h09, 3'h3, 12'h10c}, '{5'h0a, 3'h3, 12'h11c}, '{5'h0c, 3'h3, 12'h118},
        '{5'h0b, 3'h3, 12'h128}, '{5'h0d, 3'h3, 12'h124}, '{5'h0e, 3'h3, 12'h134},
        '{5'h0f, 3'h3, 12'h140}, '{5'h18, 3'h4, 12'h138}, '{5'h14, 3'h4, 12'h118},
        '{5'h12, 3'h4, 12'h11c}, '{5'h13, 3'h4, 12'h128}, '{5'h15, 3'h4, 12'h124},
        '{5'h19, 3'h4, 12'h144}, '{5'h16, 3'h4, 12'h134}, '{5'h1a, 3'h4, 12'h154},
        '{5'h1c, 3'h4, 12'h150}, '{5'h17, 3'h4, 12'h140}, '{5'h1b, 3'h4, 12'h160},
        '{5'h1d, 3'h4, 12'h15c}, '{5'h1e, 3'h4, 12'h16c}, '{5'h1f, 3'h4, 12'h178}};

    cfg_port_if cfg_port_if_i ();

    cfg_space_device cfg_space_device_i (
        .clock          (clock),
        .srst           (srst),
        .cfg            (cfg_port_if_i.device),
        .cap_enable     (cap_enable),
        .cap_base_out   (cap_base_out),
        .ext_free_base  (ext_free_base),
        .user_space_hit (user_space_hit),
        .write_dropped  (write_dropped)
    );

    cfg_space_requester cfg_space_requester_i (
        .clock         (clock),
        .srst          (srst),
        .cfg           (cfg_port_if_i.requester),
        .req_valid     (req_valid),
        .req_write     (req_write),
        .req_read      (req_read),
        .req_byte_addr (req_byte_addr),
        .req_wdata     (req_wdata),
        .req_byte_en   (req_byte_en),
        .req_ready     (req_ready),
        .resp_valid    (resp_valid),
        .resp_rdata    (resp_rdata)
    );

    config_port_ext_cap_map_props config_port_ext_cap_map_props_i (
        .clock             (clock),
        .srst              (srst),
        .cfg_dwaddr        (cfg_port_if_i.cfg_dwaddr),
        .cfg_write_data_in (cfg_port_if_i.cfg_write_data_in),
        .cfg_byte_en       (cfg_port_if_i.cfg_byte_en),
        .cfg_wr_en         (cfg_port_if_i.cfg_wr_en),
        .cfg_rd_en         (cfg_port_if_i.cfg_rd_en),
        .cfg_read_data     (cfg_port_if_i.cfg_read_data),
        .cfg_rd_wr_done    (cfg_port_if_i.cfg_rd_wr_done)
    );

    always #2 clock = ~clock;

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_base(input string what, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // caps are a strap, so each combination needs its own reset
    task automatic apply_reset(input logic [4:0] en);
        @(posedge clock);
        cap_enable <= en;
        srst <= 1'b1;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
    endtask

    task automatic access(input logic [1:0] op, input logic [11:0] addr,
                          input logic [31:0] data, input logic [3:0] be);
        int n;
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= op[1];
        req_read <= op[0];
        req_byte_addr <= addr;
        req_wdata <= data;
        req_byte_en <= be;
        @(posedge clock);
        req_valid <= 1'b0;
        #1 check_base("dword address", {2'b00, addr[11:2]}, {2'b00, cfg_port_if_i.cfg_dwaddr});
        n = 0;
        while (resp_valid !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1 n++;
            hit_seen = hit_seen | user_space_hit;
            drop_seen = drop_seen | write_dropped;
        end
        check_word("response", 32'h1, {31'b0, resp_valid});
        rd = resp_rdata;
    endtask

    task automatic write_read(input logic [11:0] addr, input logic [31:0] data,
                              input logic [3:0] be, input logic [31:0] exp,
                              input logic exp_hit, input logic exp_drop);
        hit_seen = 1'b0;
        drop_seen = 1'b0;
        access(2'b10, addr, data, be);
        access(2'b01, addr, '0, '0);
        check_word("read back", exp, rd);
        check_word("user space hit", {31'b0, exp_hit}, {31'b0, hit_seen});
        check_word("write dropped", {31'b0, exp_drop}, {31'b0, drop_seen});
    endtask

    initial begin
        foreach (rows[i]) begin
            apply_reset(rows[i].en);
            #1 check_base("cap base", rows[i].base, cap_base_out[rows[i].idx]);
        end
        apply_reset(5'h1f);
        #1 check_base("free base", 12'h184, ext_free_base);
        access(2'b01, 12'h100, '0, '0);
        check_word("dsn header", 32'h10c1_0003, rd);
        access(2'b01, 12'h10c, '0, '0);
        check_word("vc header", 32'h1281_0002, rd);
        access(2'b01, 12'h178, '0, '0);
        check_word("last header", 32'h0001_0015, rd);
        write_read(12'h110, 32'haabbccdd, 4'hf, 32'haabbccdd, 1'b0, 1'b0);
        write_read(12'h110, 32'h11223344, 4'h4, 32'haa22ccdd, 1'b0, 1'b0);
        write_read(12'h100, 32'hffffffff, 4'hf, 32'h10c1_0003, 1'b0, 1'b1);
        write_read(12'h004, 32'hffffffff, 4'hf, 32'h0000_0545, 1'b0, 1'b0);
        write_read(12'h010, 32'hffffffff, 4'hf, 32'hffff_ffff, 1'b0, 1'b0);
        write_read(12'h200, 32'h12345678, 4'hf, 32'h0000_0000, 1'b1, 1'b1);
        // a write that also asks for a read must still land
        access(2'b11, 12'h114, 32'h5a5a_5a5a, 4'hf);
        access(2'b01, 12'h114, '0, '0);
        check_word("write wins", 32'h5a5a_5a5a, rd);
        // a reset in mid-run clears storage and leaves the requester idle
        apply_reset(5'h1f);
        #1 check_word("ready after reset", 32'h1, {31'b0, req_ready});
        access(2'b01, 12'h110, '0, '0);
        check_word("cleared body", 32'h0, rd);
        complete_run();
    end

    // generous bound: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        $display("unexpected run length: expected under 5000 cycles seen 5000");
        complete_run();
    end
endmodule // config_port_ext_cap_map_tb
`default_nettype wire
